// ==== common/serial_cmd_pkg.sv ====
// Shared constants, states and carriers of the serial channel command port
package serial_cmd_pkg;
	// ==========================================================
	// Register map and bus
	localparam int ADDR_W = 12;
	localparam logic [11:0] CMD_WORD_OFF = 12'h000;
	localparam logic [11:0] DATA_BYTE_OFF = 12'h004;
	localparam int NUM_CH = 8;
	localparam logic [15:0] CMD_WORD_RST = 16'h0000;
	localparam logic [7:0] DATA_BYTE_RST = 8'h00;
	// ==========================================================
	// Command word fields
	localparam int IGNORE_BIT = 31;
	localparam int WR_BIT = 15;
	localparam int PROC_RST_BIT = 14;
	localparam int REQ_BIT = 13;
	localparam int XCHG_BIT = 12;
	localparam int SS_BIT = 11;
	localparam int TYPE_HI = 10;
	localparam int TYPE_LO = 8;
	localparam logic [2:0] TYPE_STOP = 3'h0;
	localparam logic [2:0] TYPE_NORMAL = 3'h1;
	localparam logic [2:0] TYPE_SETUP = 3'h7;
	localparam logic [15:0] HALT_EVERY_CHANNEL_CMD = 16'h0800;
	// ==========================================================
	// Local parameters
	localparam logic [7:0] LP_KIND = 8'h00;
	localparam logic [7:0] LP_WIDTH = 8'h01;
	localparam logic [7:0] LP_REV_HI = 8'h02;
	localparam logic [7:0] LP_REV_LO = 8'h03;
	localparam logic [7:0] LP_SPARE_IN = 8'h04;
	localparam logic [7:0] LP_SPARE_OUT = 8'h05;
	localparam logic [7:0] LP_PROC = 8'h06;
	localparam logic [7:0] LP_CHANS = 8'h07;
	localparam logic [7:0] LP_SCRATCH_BASE = 8'h08;
	localparam int SCRATCH_N = 8;
	// Arbitrary identification values
	localparam logic [7:0] IFACE_KIND_CODE = 8'h5A;
	localparam logic [7:0] PROC_KIND_CODE = 8'h3C;
	localparam logic [7:0] DATA_PORT_WIDTH = 8'h08;
	localparam logic [7:0] FIRMWARE_REV_HIGH = 8'h01;
	localparam logic [7:0] FIRMWARE_REV_LOW = 8'h00;
	localparam logic [7:0] SPARE_IN_COUNT = 8'h00;
	localparam logic [7:0] SPARE_OUT_COUNT = 8'h00;
	localparam logic [7:0] CHAN_COUNT = 8'h08;
	// ==========================================================
	// Remote operations and states
	typedef enum logic [2:0] {
		OP_PROBE, OP_IDENT, OP_CLR_FAULT, OP_SET_MODE, OP_OUT_OFF, OP_CHATTER, OP_EXCHANGE
	} remote_op_e;
	typedef enum logic [3:0] {
		C_IDLE, C_PROBE, C_IDENT, C_CLEAR, C_MODE, C_OFF, C_CHAT, C_RUN, C_XCHG
	} chan_state_e;
	typedef enum logic [1:0] {M_IDLE, M_CHAN, M_DONE} main_state_e;
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_s;
	typedef struct packed {
		logic valid;
		remote_op_e op;
	} remote_req_s;
	typedef struct packed {
		logic done;
		logic ok;
	} remote_rsp_s;
endpackage

// ==== verification/remote_dev_model.sv ====
// Behavioural remote field devices, one per serial channel
`timescale 1ns/1ps
module remote_dev_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] present,
	input wire serial_cmd_pkg::remote_req_s [serial_cmd_pkg::NUM_CH-1:0] req,
	output serial_cmd_pkg::remote_rsp_s [serial_cmd_pkg::NUM_CH-1:0] rsp
);
	import serial_cmd_pkg::*;
	logic [3:0] cnt [NUM_CH];
	// =====
	// Answers, later on higher channels
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < NUM_CH; i++) begin
			rsp[i].done <= 1'b0;
			// Toggles outside done so a stale ok is never trusted
			rsp[i].ok <= ~rsp[i].ok;
			if (rst) begin
				cnt[i] <= 4'h0;
				rsp[i].ok <= 1'b0;
			end else if (!req[i].valid || rsp[i].done) begin
				cnt[i] <= 4'h0;
			end else if (cnt[i] == 4'(i + 3)) begin
				rsp[i].done <= 1'b1;
				rsp[i].ok <= present[i];
			end else begin
				cnt[i] <= cnt[i] + 4'h1;
			end
		end
	end
endmodule // remote_dev_model

// ==== verification/serial_cmd_port_chk.sv ====
// Assertion checker for the serial channel command port
`timescale 1ns/1ps
module serial_cmd_port_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire serial_cmd_pkg::apb_req_s apb_req,
	input wire serial_cmd_pkg::apb_rsp_s apb_rsp,
	input wire serial_cmd_pkg::remote_rsp_s [serial_cmd_pkg::NUM_CH-1:0] rmt_rsp,
	input wire serial_cmd_pkg::remote_req_s [serial_cmd_pkg::NUM_CH-1:0] rmt_req
);
	import serial_cmd_pkg::*;
	// =====
	// Decodes
	wire logic acc = apb_req.psel && apb_req.penable;
	wire logic hit = apb_req.paddr == CMD_WORD_OFF || apb_req.paddr == DATA_BYTE_OFF;
	wire logic rd = apb_rsp.pready && !apb_req.pwrite;
	wire logic halt_wr = acc && !apb_rsp.pready && apb_req.pwrite
		&& apb_req.paddr == CMD_WORD_OFF && apb_req.pwdata == {16'h0000, HALT_EVERY_CHANNEL_CMD};
	logic [NUM_CH-1:0] vld;
	always_comb for (int i = 0; i < NUM_CH; i++) vld[i] = rmt_req[i].valid;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// =====
	// Properties
	a_ready_one_wait: assert property ($rose(acc) |-> !apb_rsp.pready ##1 apb_rsp.pready)
		else $error("pready not one wait state after access");
	a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready longer than one cycle");
	a_no_stray_ready: assert property (!acc |=> !apb_rsp.pready)
		else $error("pready without access");
	a_err_unmapped: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !hit)
		else $error("pslverr does not match decode");
	a_cmd_upper_zero: assert property (rd && apb_req.paddr == CMD_WORD_OFF
		|-> apb_rsp.prdata[31:16] == 16'h0000)
		else $error("command upper bits not zero");
	a_data_upper_zero: assert property (rd && apb_req.paddr == DATA_BYTE_OFF
		|-> apb_rsp.prdata[31:8] == 24'h000000)
		else $error("data upper bits not zero");
	a_req_holds: assert property (rmt_req[0].valid && !rmt_rsp[0].done |=> rmt_req[0].valid)
		else $error("remote request dropped before done");
	a_ident_after_probe: assert property (rmt_req[0].valid && rmt_req[0].op == OP_PROBE
		&& rmt_rsp[0].done && rmt_rsp[0].ok |=> rmt_req[0].valid && rmt_req[0].op == OP_IDENT)
		else $error("no identify request after a good probe");
	a_chat_after_off: assert property (rmt_req[0].valid && rmt_req[0].op == OP_OUT_OFF
		&& rmt_rsp[0].done && rmt_rsp[0].ok |=> rmt_req[0].valid && rmt_req[0].op == OP_CHATTER)
		else $error("no keep-alive after outputs off");
	a_halt_idles: assert property (halt_wr |-> ##2 vld == '0)
		else $error("halt left a channel busy");
	a_reset_idle: assert property ($fell(rst) |-> !apb_rsp.pready && vld == '0)
		else $error("not idle after reset");
endmodule // serial_cmd_port_chk

bind serial_cmd_port serial_cmd_port_chk i_serial_cmd_port_chk (.sys_clk(sys_clk), .rst(rst),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .rmt_rsp(rmt_rsp), .rmt_req(rmt_req));

// ==== verification/tb_top.sv ====
// Self-checking testbench for the serial channel command port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
	import serial_cmd_pkg::*;
	logic sys_clk;
	logic rst;
	apb_req_s apb_req;
	apb_rsp_s apb_rsp;
	remote_rsp_s [NUM_CH-1:0] rmt_rsp;
	remote_req_s [NUM_CH-1:0] rmt_req;
	logic [7:0] present;
	logic [31:0] v;
	logic err;
	int n_mismatch = 0;
	int cmp_count = 0;
	logic [7:0] lp [8];

	serial_cmd_port i_serial_cmd_port (.sys_clk(sys_clk), .rst(rst), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .rmt_rsp(rmt_rsp), .rmt_req(rmt_req));
	remote_dev_model i_remote_dev_model (.sys_clk(sys_clk), .rst(rst), .present(present),
		.req(rmt_req), .rsp(rmt_rsp));

	// =====
	// Bus tasks
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge sys_clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 40);
		v = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		if (n >= 40) begin
			n_mismatch++;
			conclude();
		end
	endtask

	task automatic poll();
		int n;
		n = 0;
		do begin
			xfer(1'b0, CMD_WORD_OFF, 32'h0);
			n++;
		end while (v !== 32'h0 && n < 100);
		`CHK("cmd clears", 32'h0, v)
		if (v !== 32'h0) conclude();
	endtask

	task automatic cmd(input logic [31:0] c, input logic [7:0] e);
		xfer(1'b1, CMD_WORD_OFF, c);
		poll();
		xfer(1'b0, DATA_BYTE_OFF, 32'h0);
		`CHK("data byte", {24'h0, e}, v)
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// =====
	// Clock, watchdog, tests
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		conclude();
	end

	initial begin
		rst = 1'b1;
		apb_req = '0;
		present = 8'hFD;
		lp = '{IFACE_KIND_CODE, 8'h08, FIRMWARE_REV_HIGH, FIRMWARE_REV_LOW,
			8'h00, 8'h00, PROC_KIND_CODE, 8'h08};
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		xfer(1'b0, CMD_WORD_OFF, 32'h0);
		`CHK("cmd reset", 32'h0, v)
		xfer(1'b0, DATA_BYTE_OFF, 32'h0);
		`CHK("data reset", 32'h0, v)
		for (int i = 0; i < 8; i++) cmd(32'h2000 | i, lp[i]);
		xfer(1'b1, DATA_BYTE_OFF, 32'hFFFF_FFA5);
		xfer(1'b1, CMD_WORD_OFF, 32'hA00B);
		poll();
		cmd(32'h200B, 8'hA5);
		$display("local parameter test done");
		xfer(1'b0, 12'h010, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, v)
		xfer(1'b1, CMD_WORD_OFF, 32'h8000_0901);
		xfer(1'b0, CMD_WORD_OFF, 32'h0);
		`CHK("ignored write", 32'h0, v)
		xfer(1'b1, CMD_WORD_OFF, 32'h0903);
		xfer(1'b1, CMD_WORD_OFF, 32'h0902);
		xfer(1'b0, CMD_WORD_OFF, 32'h0);
		`CHK("busy cmd", 32'h0903, v)
		poll();
		xfer(1'b0, DATA_BYTE_OFF, 32'h0);
		`CHK("start mask", 32'h02, v)
		cmd(32'h1001, 8'h00);
		cmd(32'h1005, 8'h04);
		cmd(32'h0F04, 8'h00);
		$display("start and exchange test done");
		xfer(1'b1, CMD_WORD_OFF, 32'h0F01);
		xfer(1'b1, CMD_WORD_OFF, 32'h0800);
		poll();
		cmd(32'h1001, 8'h01);
		cmd(32'h0901, 8'h00);
		xfer(1'b1, CMD_WORD_OFF, 32'h0801);
		poll();
		cmd(32'h1001, 8'h01);
		cmd(32'h0901, 8'h00);
		cmd(32'h1001, 8'h00);
		$display("stop test done");
		conclude();
	end
endmodule // tb_top

// ==== verilog/chan_link.sv ====
// Per-channel start, keep-alive and exchange sequencer
`timescale 1ns/1ps
module chan_link (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clear_p,
	input wire logic stop_p,
	input wire logic start_p,
	input wire logic setup_mode,
	input wire logic xchg_p,
	input wire serial_cmd_pkg::remote_rsp_s rsp,
	output serial_cmd_pkg::remote_req_s req_r,
	output logic done_r,
	output logic fail_r
);
	import serial_cmd_pkg::*;

	chan_state_e st_r;
	logic setup_r;
	logic xpend_r;
	wire ack = req_r.valid & rsp.done;

	always_ff @(posedge sys_clk) begin
		done_r <= 1'b0;
		if (rst || clear_p) begin
			st_r <= C_IDLE;
			setup_r <= 1'b0;
			xpend_r <= 1'b0;
			req_r <= '{valid: 1'b0, op: OP_PROBE};
			fail_r <= 1'b0;
		end else if (stop_p) begin
			// Individual stop leaves channel variables as they are
			st_r <= C_IDLE;
			xpend_r <= 1'b0;
			req_r.valid <= 1'b0;
		end else begin
			if (ack)
				req_r.valid <= 1'b0;
			unique case (st_r)
			C_IDLE: begin
				if (start_p) begin
					setup_r <= setup_mode;
					st_r <= C_PROBE;
					req_r <= '{valid: 1'b1, op: OP_PROBE};
				end else if (xchg_p) begin
					done_r <= 1'b1;
					fail_r <= 1'b1;
				end
			end
			C_PROBE, C_IDENT, C_CLEAR, C_MODE, C_OFF: begin
				if (xchg_p) begin
					done_r <= 1'b1;
					fail_r <= 1'b1;
				end else if (ack && !rsp.ok) begin
					st_r <= C_IDLE;
					done_r <= 1'b1;
					fail_r <= 1'b1;
				end else if (ack) begin
					unique case (st_r)
					C_PROBE: begin
						st_r <= C_IDENT;
						req_r <= '{valid: 1'b1, op: OP_IDENT};
					end
					C_IDENT: begin
						if (setup_r) begin
							st_r <= C_RUN;
							done_r <= 1'b1;
							fail_r <= 1'b0;
						end else begin
							st_r <= C_CLEAR;
							req_r <= '{valid: 1'b1, op: OP_CLR_FAULT};
						end
					end
					C_CLEAR: begin
						st_r <= C_MODE;
						req_r <= '{valid: 1'b1, op: OP_SET_MODE};
					end
					C_MODE: begin
						st_r <= C_OFF;
						req_r <= '{valid: 1'b1, op: OP_OUT_OFF};
					end
					default: begin
						st_r <= C_CHAT;
						done_r <= 1'b1;
						fail_r <= 1'b0;
						req_r <= '{valid: 1'b1, op: OP_CHATTER};
					end
					endcase
				end
			end
			C_CHAT: begin
				if (xchg_p)
					xpend_r <= 1'b1;
				if (ack || !req_r.valid) begin
					if (xchg_p || xpend_r) begin
						st_r <= C_XCHG;
						xpend_r <= 1'b0;
						req_r <= '{valid: 1'b1, op: OP_EXCHANGE};
					end else begin
						req_r <= '{valid: 1'b1, op: OP_CHATTER};
					end
				end
			end
			C_RUN: begin
				if (xchg_p) begin
					st_r <= C_XCHG;
					req_r <= '{valid: 1'b1, op: OP_EXCHANGE};
				end
			end
			C_XCHG: begin
				if (ack) begin
					st_r <= C_RUN;
					done_r <= 1'b1;
					fail_r <= ~rsp.ok;
				end
			end
			default: st_r <= C_IDLE;
			endcase
		end
	end
endmodule // chan_link

// ==== verilog/serial_cmd_port.sv ====
// Host command and data register port for the multi-channel serial link
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// ==========================================================
// Overview of operation
// - Command register holds 16 bits in the low end of a 32-bit word.
// - Bit 15 marks a write, bit 14 processor reset, bit 13 a request.
// - Bit 12 selects data exchange; bit 11 start/stop with type bits 10..8.
// - Start/stop with type 000 stops the masked channels.
// - Start/stop with type 001 starts masked channels in normal mode.
// - Start/stop with type 111 starts masked channels in setup mode.
// - Each set low bit selects its channel; clear bits leave channels alone.
// - A write begins the command; clearing the register signals completion.
// - Reads before completion return the command being executed.
// - Command writes with bit 31 set are dropped.
// - An 8-bit data register sits at the low end of a 32-bit word.
// - Addresses 0..7 hold read-only identity, width, revisions, counts.
// - Channel count always reads 8 (CHAN_COUNT).
// - Reset initialises channel state; reset or stop leaves channels idle.
// - Start probes masked channels and fetches name, unit and pointers.
// - Normal start clears faults, sets mode, outputs off, then keeps alive.
// - After start the data register flags channels that failed to start.
// - Halt-all word resets channel variables; a full-mask stop does not.
// - After exchange the data register holds a per-channel fault mask.
module serial_cmd_port (
	input wire logic sys_clk,
	input wire logic rst,
	input wire serial_cmd_pkg::apb_req_s apb_req,
	output serial_cmd_pkg::apb_rsp_s apb_rsp,
	input wire serial_cmd_pkg::remote_rsp_s [serial_cmd_pkg::NUM_CH-1:0] rmt_rsp,
	output serial_cmd_pkg::remote_req_s [serial_cmd_pkg::NUM_CH-1:0] rmt_req
);
	import serial_cmd_pkg::*;

	// ==========================================================
	// Functions
	function automatic logic [7:0] local_param(input logic [7:0] addr,
		input logic [7:0] scratch [SCRATCH_N]);
		logic [7:0] v;
		v = 8'h00;
		unique case (addr)
		LP_KIND: v = IFACE_KIND_CODE;
		LP_WIDTH: v = DATA_PORT_WIDTH;
		LP_REV_HI: v = FIRMWARE_REV_HIGH;
		LP_REV_LO: v = FIRMWARE_REV_LOW;
		LP_SPARE_IN: v = SPARE_IN_COUNT;
		LP_SPARE_OUT: v = SPARE_OUT_COUNT;
		LP_PROC: v = PROC_KIND_CODE;
		LP_CHANS: v = CHAN_COUNT;
		default: begin
			if (is_scratch(addr))
				v = scratch[addr[2:0]];
		end
		endcase
		return v;
	endfunction

	function automatic logic is_scratch(input logic [7:0] addr);
		return addr >= LP_SCRATCH_BASE && addr < LP_SCRATCH_BASE + 8'(SCRATCH_N);
	endfunction

	// ==========================================================
	// Register state
	logic [15:0] cmd_word_r;
	logic [7:0] data_byte_r;
	logic [7:0] scratch_r [SCRATCH_N];
	main_state_e mst_r;
	logic [7:0] pend_r;
	logic [7:0] fail_acc_r;
	logic [NUM_CH-1:0] clear_p_r;
	logic [NUM_CH-1:0] stop_p_r;
	logic [NUM_CH-1:0] start_p_r;
	logic [NUM_CH-1:0] xchg_p_r;
	logic setup_r;
	logic [NUM_CH-1:0] ch_done;
	logic [NUM_CH-1:0] ch_fail;

	// ==========================================================
	// Bus decode
	// One wait state: pready rises the cycle after penable
	wire access = apb_req.psel & apb_req.penable & ~apb_rsp.pready;
	wire hit_cmd = apb_req.paddr == CMD_WORD_OFF;
	wire hit_data = apb_req.paddr == DATA_BYTE_OFF;
	wire wr_cmd = access & apb_req.pwrite & hit_cmd;
	wire wr_data = access & apb_req.pwrite & hit_data;
	wire ignored = apb_req.pwdata[IGNORE_BIT];
	wire [15:0] new_cmd = apb_req.pwdata[15:0];
	wire is_halt_all = new_cmd == HALT_EVERY_CHANNEL_CMD;
	// Busy writes other than halt-all are dropped to protect the running command
	wire take_cmd = wr_cmd & ~ignored & (cmd_word_r == CMD_WORD_RST | is_halt_all);
	wire [31:0] rd_word = hit_cmd ? {16'h0000, cmd_word_r} :
		{24'h000000, data_byte_r};

	// ==========================================================
	// Command decode
	wire [7:0] mask = new_cmd[7:0];
	wire [2:0] cmd_type = new_cmd[TYPE_HI:TYPE_LO];
	wire d_reset = new_cmd[PROC_RST_BIT] | is_halt_all;
	wire d_req = new_cmd[REQ_BIT];
	wire d_write = new_cmd[WR_BIT];
	wire d_xchg = new_cmd[XCHG_BIT];
	wire d_ss = new_cmd[SS_BIT];
	wire d_stop = d_ss & cmd_type == TYPE_STOP;
	wire d_start = d_ss & (cmd_type == TYPE_NORMAL | cmd_type == TYPE_SETUP);
	wire d_setup = cmd_type == TYPE_SETUP;
	wire [7:0] lp_addr = new_cmd[7:0];
	wire chan_cmd = d_start | d_xchg;
	wire [7:0] pend_nxt = pend_r & ~ch_done;
	wire [7:0] fail_nxt = fail_acc_r | (ch_done & ch_fail);
	// Exchanges carry type 000 too, so of the start/stop words only a stop skips the fail mask
	wire mask_result = ~cmd_word_r[REQ_BIT] & (cmd_word_r[XCHG_BIT] |
		(cmd_word_r[SS_BIT] & (cmd_word_r[TYPE_HI:TYPE_LO] != TYPE_STOP)));

	// ==========================================================
	// Bus slave
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			apb_rsp <= '{prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0};
		end else begin
			apb_rsp.pready <= access;
			apb_rsp.pslverr <= access & ~(hit_cmd | hit_data);
			if (access & ~apb_req.pwrite)
				apb_rsp.prdata <= (hit_cmd | hit_data) ? rd_word : 32'h00000000;
		end
	end

	// ==========================================================
	// Command sequencer
	always_ff @(posedge sys_clk) begin
		clear_p_r <= '0;
		stop_p_r <= '0;
		start_p_r <= '0;
		xchg_p_r <= '0;
		if (rst) begin
			cmd_word_r <= CMD_WORD_RST;
			data_byte_r <= DATA_BYTE_RST;
			mst_r <= M_IDLE;
			pend_r <= 8'h00;
			fail_acc_r <= 8'h00;
			setup_r <= 1'b0;
			for (int i = 0; i < SCRATCH_N; i++)
				scratch_r[i] <= 8'h00;
		end else if (take_cmd) begin
			cmd_word_r <= new_cmd;
			mst_r <= M_DONE;
			setup_r <= d_setup;
			if (d_reset) begin
				clear_p_r <= '1;
			end else if (d_req) begin
				if (d_write && is_scratch(lp_addr))
					scratch_r[lp_addr[2:0]] <= data_byte_r;
				else if (!d_write)
					data_byte_r <= local_param(lp_addr, scratch_r);
			end else if (d_stop) begin
				stop_p_r <= mask;
			end else if (chan_cmd) begin
				mst_r <= M_CHAN;
				pend_r <= mask;
				fail_acc_r <= 8'h00;
				start_p_r <= d_start ? mask : 8'h00;
				xchg_p_r <= d_xchg ? mask : 8'h00;
			end
		end else begin
			if (wr_data)
				data_byte_r <= apb_req.pwdata[7:0];
			unique case (mst_r)
			M_IDLE: ;
			M_CHAN: begin
				pend_r <= pend_nxt;
				fail_acc_r <= fail_nxt;
				if (pend_nxt == 8'h00)
					mst_r <= M_DONE;
			end
			M_DONE: begin
				if (mask_result)
					data_byte_r <= fail_acc_r;
				cmd_word_r <= CMD_WORD_RST;
				mst_r <= M_IDLE;
			end
			endcase
		end
	end

	// ==========================================================
	// Channels
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		chan_link u_chan (
			.sys_clk(sys_clk),
			.rst(rst),
			.clear_p(clear_p_r[c]),
			.stop_p(stop_p_r[c]),
			.start_p(start_p_r[c]),
			.setup_mode(setup_r),
			.xchg_p(xchg_p_r[c]),
			.rsp(rmt_rsp[c]),
			.req_r(rmt_req[c]),
			.done_r(ch_done[c]),
			.fail_r(ch_fail[c])
		);
	end
endmodule // serial_cmd_port
